//--- hdl/irqps_pkg.sv
// Register map, field layout and reset values of the priority and system register block
//
// Contract
// [R1] Four two-bit level fields per register, reset zero
// [R2] Level zero most urgent, three least urgent
// [R3] Low register holds levels of interrupts 24-27
// [R4] High register holds 28-31, decoded at 0x031C
// [R5] Reserved bits read zero, writes ignored
// [R6] Identification at 0x0000, control-state at 0x0004
// [R7] Reset control at 0x000C, resets to 0xFA05_0000
// [R8] System control 0x0010, handler priorities 0x001C/0x0020
// [R9] Fixed implementer and part fields, 23:20 zero
// [R10] Architecture 19:16 and revision 3:0, revision resets zero
// [R11] Processor uses aligned 32-bit word accesses only
`default_nettype none

package irqps_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;

    // Window bases: interrupt controller and system control space
    localparam logic [11:0] NVIC_BASE = 12'h000;
    localparam logic [11:0] SCS_BASE  = 12'hd00;

    // Interrupt controller offsets
    localparam logic [11:0] OFF_IRQ24_27 = 12'h318;
    localparam logic [11:0] OFF_IRQ28_31 = 12'h31c;

    // System control space offsets
    localparam logic [11:0] OFF_ID    = 12'h000;
    localparam logic [11:0] OFF_ICSR  = 12'h004;
    localparam logic [11:0] OFF_AIRCR = 12'h00c;
    localparam logic [11:0] OFF_SCR   = 12'h010;
    localparam logic [11:0] OFF_SHPR2 = 12'h01c;
    localparam logic [11:0] OFF_SHPR3 = 12'h020;

    // Reset values
    localparam logic [31:0] ICSR_RST  = 32'h0000_0000;
    localparam logic [31:0] AIRCR_RST = 32'hfa05_0000;
    localparam logic [31:0] SCR_RST   = 32'h0000_0000;
    localparam logic [31:0] SHPR_RST  = 32'h0000_0000;
    localparam logic [1:0]  LEVEL_RST = 2'h0;
    localparam logic [3:0]  REV_RST   = 4'h0;

    // Priority field layout
    localparam int unsigned NUM_IRQ    = 8;
    localparam int unsigned PER_REG    = 4;
    localparam int unsigned LEVEL_W    = 2;
    localparam int unsigned LEVEL_LSB  = 6;
    localparam int unsigned LEVEL_STEP = 8;
    localparam logic [4:0]  IRQ_FIRST  = 5'h18;

    // Identification field positions
    localparam int unsigned IMPL_LSB = 24;
    localparam int unsigned ARCH_LSB = 16;
    localparam int unsigned PART_LSB = 4;
    localparam int unsigned REV_LSB  = 0;

    // Identity defaults (values are arbitrary)
    localparam logic [7:0]  IMPL_DEFAULT = 8'h5a;
    localparam logic [11:0] PART_DEFAULT = 12'h123;
    localparam logic [3:0]  ARCH_DEFAULT = 4'h1;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Register selected by an address
    typedef enum logic [3:0] {
        REG_NONE,
        REG_ID,
        REG_ICSR,
        REG_AIRCR,
        REG_SCR,
        REG_SHPR2,
        REG_SHPR3,
        REG_PRI_LO,
        REG_PRI_HI
    } irqps_reg_e;

    typedef logic [1:0] irqps_level_t;

    // Arbitration result
    typedef struct packed {
        logic         valid;
        logic [4:0]   id;
        irqps_level_t level;
    } irqps_win_s;

endpackage

`default_nettype wire

//--- hdl/irqps_regs.sv
// Priority registers for interrupts 24-31 and the system control register map
`default_nettype none

module irqps_regs #(
    parameter logic [7:0]  IMPLEMENTER_CODE = irqps_pkg::IMPL_DEFAULT,
    parameter logic [11:0] PART_NUMBER      = irqps_pkg::PART_DEFAULT,
    parameter logic [3:0]  ARCH_CODE_RST    = irqps_pkg::ARCH_DEFAULT
) (
    // Clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,

    // Write address channel
    input  wire logic [irqps_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                         awvalid,
    output logic                              awready,

    // Write data channel
    input  wire logic [irqps_pkg::DATA_W-1:0] wdata,
    input  wire logic [irqps_pkg::STRB_W-1:0] wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,

    // Write response channel
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,

    // Read address channel
    input  wire logic [irqps_pkg::ADDR_W-1:0] araddr,
    input  wire logic                         arvalid,
    output logic                              arready,

    // Read data channel
    output logic [irqps_pkg::DATA_W-1:0]      rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,

    // Interrupt side: pending lines 24-31 and their levels
    input  wire logic [7:0]                   irq_pending,
    output irqps_pkg::irqps_level_t [7:0]     level_irq,
    output irqps_pkg::irqps_win_s             win
);

    // Stored state
    logic [irqps_pkg::ADDR_W-1:0] aw_addr_q;
    logic                         aw_full_q;
    logic [irqps_pkg::DATA_W-1:0] w_data_q;
    logic [irqps_pkg::STRB_W-1:0] w_strb_q;
    logic                         w_full_q;
    logic                         bvalid_q;
    logic [1:0]                   bresp_q;
    logic                         rvalid_q;
    logic [1:0]                   rresp_q;
    logic [31:0]                  rdata_q;

    logic [31:0]                  icsr_q;
    logic [31:0]                  aircr_q;
    logic [31:0]                  scr_q;
    logic [31:0]                  shpr2_q;
    logic [31:0]                  shpr3_q;
    logic [3:0]                   arch_q;
    logic [3:0]                   rev_q;
    irqps_pkg::irqps_level_t [7:0] level_q;
    irqps_pkg::irqps_win_s        win_q;
    irqps_pkg::irqps_win_s        win_d;

    // Decode and datapath wires
    irqps_pkg::irqps_reg_e        wr_sel;
    irqps_pkg::irqps_reg_e        rd_sel;
    logic                         wr_fire;
    logic                         rd_fire;
    logic [31:0]                  wr_mask;
    logic [31:0]                  rd_word;

    // Maps a byte address onto a register
    function automatic irqps_pkg::irqps_reg_e decode(input logic [11:0] a);
        irqps_pkg::irqps_reg_e s;
        s = irqps_pkg::REG_NONE;
        if (a == irqps_pkg::SCS_BASE + irqps_pkg::OFF_ID) begin // [R6]
            s = irqps_pkg::REG_ID;
        end else if (a == irqps_pkg::SCS_BASE + irqps_pkg::OFF_ICSR) begin // [R6]
            s = irqps_pkg::REG_ICSR;
        end else if (a == irqps_pkg::SCS_BASE + irqps_pkg::OFF_AIRCR) begin // [R7]
            s = irqps_pkg::REG_AIRCR;
        end else if (a == irqps_pkg::SCS_BASE + irqps_pkg::OFF_SCR) begin // [R8]
            s = irqps_pkg::REG_SCR;
        end else if (a == irqps_pkg::SCS_BASE + irqps_pkg::OFF_SHPR2) begin // [R8]
            s = irqps_pkg::REG_SHPR2;
        end else if (a == irqps_pkg::SCS_BASE + irqps_pkg::OFF_SHPR3) begin // [R8]
            s = irqps_pkg::REG_SHPR3;
        end else if (a == irqps_pkg::NVIC_BASE + irqps_pkg::OFF_IRQ24_27) begin // [R3]
            s = irqps_pkg::REG_PRI_LO;
        end else if (a == irqps_pkg::NVIC_BASE + irqps_pkg::OFF_IRQ28_31) begin // [R4]
            s = irqps_pkg::REG_PRI_HI;
        end
        return s;
    endfunction

    // Merges written bytes into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m);
        return (old & ~m) | (w_data_q & m);
    endfunction

    // Handshake outputs
    assign awready = !aw_full_q;
    assign wready  = !w_full_q;
    assign arready = !rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;
    assign level_irq = level_q;
    assign win       = win_q;

    // Commit once both halves of a write are held and no answer is owed
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
    assign rd_fire = arvalid && !rvalid_q;
    assign wr_sel  = decode(aw_addr_q);
    assign rd_sel  = decode(araddr);

    // Byte strobes widened to a bit mask; word writes are the normal case
    assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                      {8{w_strb_q[1]}}, {8{w_strb_q[0]}}}; // [R11]

    // Write address holding stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 12'h000;
        end else if (awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end
    end

    // Write data holding stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer with a decode error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= irqps_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_sel == irqps_pkg::REG_NONE) ? irqps_pkg::RESP_DECERR
                                                        : irqps_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // System control space storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            icsr_q  <= irqps_pkg::ICSR_RST; // [R6]
            aircr_q <= irqps_pkg::AIRCR_RST; // [R7]
            scr_q   <= irqps_pkg::SCR_RST; // [R8]
            shpr2_q <= irqps_pkg::SHPR_RST; // [R8]
            shpr3_q <= irqps_pkg::SHPR_RST; // [R8]
        end else if (wr_fire) begin
            case (wr_sel)
                irqps_pkg::REG_ICSR:  icsr_q  <= merge(icsr_q, wr_mask);
                irqps_pkg::REG_AIRCR: aircr_q <= merge(aircr_q, wr_mask);
                irqps_pkg::REG_SCR:   scr_q   <= merge(scr_q, wr_mask);
                irqps_pkg::REG_SHPR2: shpr2_q <= merge(shpr2_q, wr_mask);
                irqps_pkg::REG_SHPR3: shpr3_q <= merge(shpr3_q, wr_mask);
                default: ;
            endcase
        end
    end

    // Writable identification fields: architecture and revision
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arch_q <= ARCH_CODE_RST; // [R10]
            rev_q  <= irqps_pkg::REV_RST; // [R10]
        end else if (wr_fire && wr_sel == irqps_pkg::REG_ID) begin
            if (w_strb_q[2]) begin
                arch_q <= w_data_q[irqps_pkg::ARCH_LSB +: 4]; // [R10]
            end
            if (w_strb_q[0]) begin
                rev_q <= w_data_q[irqps_pkg::REV_LSB +: 4]; // [R10]
            end
        end
    end

    // One level field per interrupt; only the field bits are stored
    for (genvar g = 0; g < 8; g++) begin : g_level
        localparam int unsigned POS = irqps_pkg::LEVEL_STEP * (g % irqps_pkg::PER_REG)
                                      + irqps_pkg::LEVEL_LSB;
        localparam irqps_pkg::irqps_reg_e HOME = (g < irqps_pkg::PER_REG)
                                      ? irqps_pkg::REG_PRI_LO // [R3]
                                      : irqps_pkg::REG_PRI_HI; // [R4]
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                level_q[g] <= irqps_pkg::LEVEL_RST; // [R1]
            end else if (wr_fire && wr_sel == HOME && w_strb_q[g % irqps_pkg::PER_REG]) begin
                level_q[g] <= w_data_q[POS +: irqps_pkg::LEVEL_W]; // [R1]
            end
        end
    end

    // Read word assembly; reserved bits stay zero
    always_comb begin
        rd_word = 32'h0000_0000; // [R5]
        case (rd_sel)
            irqps_pkg::REG_ID: begin
                rd_word[irqps_pkg::IMPL_LSB +: 8]  = IMPLEMENTER_CODE; // [R9]
                rd_word[irqps_pkg::ARCH_LSB +: 4]  = arch_q; // [R10]
                rd_word[irqps_pkg::PART_LSB +: 12] = PART_NUMBER; // [R9]
                rd_word[irqps_pkg::REV_LSB +: 4]   = rev_q; // [R10]
            end
            irqps_pkg::REG_ICSR:  rd_word = icsr_q;
            irqps_pkg::REG_AIRCR: rd_word = aircr_q;
            irqps_pkg::REG_SCR:   rd_word = scr_q;
            irqps_pkg::REG_SHPR2: rd_word = shpr2_q;
            irqps_pkg::REG_SHPR3: rd_word = shpr3_q;
            irqps_pkg::REG_PRI_LO: begin
                for (int i = 0; i < 4; i++) begin
                    rd_word[irqps_pkg::LEVEL_STEP*i + irqps_pkg::LEVEL_LSB +: 2]
                        = level_q[i]; // [R3]
                end
            end
            irqps_pkg::REG_PRI_HI: begin
                for (int i = 0; i < 4; i++) begin
                    rd_word[irqps_pkg::LEVEL_STEP*i + irqps_pkg::LEVEL_LSB +: 2]
                        = level_q[i + 4]; // [R4]
                end
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Read answer, registered on the same edge that takes the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= irqps_pkg::RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= (rd_sel == irqps_pkg::REG_NONE) ? irqps_pkg::RESP_DECERR
                                                        : irqps_pkg::RESP_OKAY;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Most urgent pending interrupt; lower level wins, ties go to lower number
    always_comb begin
        win_d = '0;
        for (int i = 0; i < 8; i++) begin
            if (irq_pending[i] && (!win_d.valid || level_q[i] < win_d.level)) begin // [R2]
                win_d.valid = 1'b1;
                win_d.id    = irqps_pkg::IRQ_FIRST + 5'(i);
                win_d.level = level_q[i];
            end
        end
    end

    // Registered arbitration result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_q <= '0;
        end else begin
            win_q <= win_d; // [R2]
        end
    end

endmodule

`default_nettype wire

//--- verification/irqps_cpu_model.sv
// Load and store master model that reaches the register block over AXI4-Lite
`default_nettype none

module irqps_cpu_model (
    // Clock
    input  wire logic                         aclk,
    // Write channels
    output logic [irqps_pkg::ADDR_W-1:0]      awaddr,
    output logic                              awvalid,
    input  wire logic                         awready,
    output logic [irqps_pkg::DATA_W-1:0]      wdata,
    output logic [irqps_pkg::STRB_W-1:0]      wstrb,
    output logic                              wvalid,
    input  wire logic                         wready,
    input  wire logic [1:0]                   bresp,
    input  wire logic                         bvalid,
    output logic                              bready,
    // Read channels
    output logic [irqps_pkg::ADDR_W-1:0]      araddr,
    output logic                              arvalid,
    input  wire logic                         arready,
    input  wire logic [irqps_pkg::DATA_W-1:0] rdata,
    input  wire logic [1:0]                   rresp,
    input  wire logic                         rvalid,
    output logic                              rready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic hung;

    // Idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        hung = 1'b0;
    end

    // Full-word aligned write; address and data released as each is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        resp = 2'h2;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hf;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 64) hung = 1'b1;
    endtask

    // Full-word aligned read; rready held until the data arrives
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        d = 32'h0;
        resp = 2'h2;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 64) hung = 1'b1;
    endtask
endmodule

`default_nettype wire

//--- verification/irqps_regs_chk.sv
// Concurrent checks on the ports of the priority and system register block
`default_nettype none

module irqps_regs_chk #(
    parameter logic [7:0]  IMPLEMENTER_CODE = irqps_pkg::IMPL_DEFAULT,
    parameter logic [11:0] PART_NUMBER      = irqps_pkg::PART_DEFAULT
) (
    // Clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // Bus handshakes and payloads
    input  wire logic                         awvalid,
    input  wire logic                         awready,
    input  wire logic                         wvalid,
    input  wire logic                         wready,
    input  wire logic                         bvalid,
    input  wire logic [irqps_pkg::ADDR_W-1:0] araddr,
    input  wire logic                         arvalid,
    input  wire logic                         arready,
    input  wire logic [irqps_pkg::DATA_W-1:0] rdata,
    input  wire logic [1:0]                   rresp,
    input  wire logic                         rvalid,
    input  wire logic                         rready,
    // Interrupt side
    input  wire logic [7:0]                   irq_pending,
    input  wire irqps_pkg::irqps_level_t [7:0] level_irq,
    input  wire irqps_pkg::irqps_win_s        win
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [11:0]                  ar_q;
    logic [7:0]                   pend_q;
    irqps_pkg::irqps_level_t [7:0] lvl_q;
    logic                         min_ok;

    // Address of the read in flight
    always_ff @(posedge aclk) begin
        if (arvalid && arready) ar_q <= araddr;
    end

    // Inputs the arbiter saw one edge earlier
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= '0;
            lvl_q  <= '0;
        end else begin
            pend_q <= irq_pending;
            lvl_q  <= level_irq;
        end
    end

    // No pending line beats the winner, ties go to the lower number
    always_comb begin
        min_ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (pend_q[i] && lvl_q[i] < win.level) min_ok = 1'b0;
            if (pend_q[i] && lvl_q[i] == win.level && i < int'(win.id[2:0])) min_ok = 1'b0;
        end
    end

    rst_clear_a: assert property (disable iff (1'b0) !aresetn |=>
        !bvalid && !rvalid && level_irq == '0 && win == '0) else $error("reset state wrong");
    rd_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered next cycle");
    rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data not held");
    wr_answer_a: assert property (awvalid && awready && wvalid && wready && !bvalid |->
        ##[1:3] bvalid) else $error("write not answered");
    pri_reserved_a: assert property (rvalid && (ar_q == irqps_pkg::OFF_IRQ24_27 ||
        ar_q == irqps_pkg::OFF_IRQ28_31) |-> (rdata & 32'h3f3f3f3f) == 32'h0)
        else $error("reserved priority bits set");
    pri_map_a: assert property (rvalid && ar_q == irqps_pkg::OFF_IRQ28_31 |->
        rdata[31:30] == level_irq[7] && rdata[7:6] == level_irq[4]) else $error("level map");
    id_fixed_a: assert property (rvalid && ar_q == irqps_pkg::SCS_BASE |->
        rdata[31:20] == {IMPLEMENTER_CODE, 4'h0} && rdata[15:4] == PART_NUMBER)
        else $error("identification fixed fields wrong");
    win_pick_a: assert property (win.valid |-> pend_q[win.id[2:0]] && win.id[4:3] == 2'h3 &&
        win.level == lvl_q[win.id[2:0]] && min_ok) else $error("wrong winner");
    win_none_a: assert property (win.valid == (pend_q != 8'h00))
        else $error("winner valid mismatch");
endmodule

bind irqps_regs irqps_regs_chk #(.IMPLEMENTER_CODE(IMPLEMENTER_CODE), .PART_NUMBER(PART_NUMBER))
    i_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .irq_pending, .level_irq, .win);

`default_nettype wire

//--- verification/irqps_regs_tb_top.sv
// Self-checking bench for the priority and system register block
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module irqps_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0]  IMPL = 8'h3c;  // Arbitrary identity value
    localparam logic [11:0] PART = 12'h2b7; // Arbitrary identity value
    localparam logic [3:0]  ARCH = 4'h6;
    localparam logic [11:0] SCS  = irqps_pkg::SCS_BASE;
    localparam logic [1:0]  OK   = irqps_pkg::RESP_OKAY;

    logic                          aclk = 1'b0;
    logic                          aresetn = 1'b0;
    logic [7:0]                    irq_pending = 8'h00;
    logic [11:0]                   awaddr, araddr;
    logic [31:0]                   wdata, rdata;
    logic [3:0]                    wstrb;
    logic [1:0]                    bresp, rresp;
    logic                          awvalid, awready, wvalid, wready, bvalid, bready;
    logic                          arvalid, arready, rvalid, rready;
    irqps_pkg::irqps_level_t [7:0] level_irq;
    irqps_pkg::irqps_win_s         win;
    int                            miscompares = 0;
    int                            num_checks = 0;

    // Clock of 4 ns
    always #2 aclk = ~aclk;

    irqps_regs #(.IMPLEMENTER_CODE(IMPL), .PART_NUMBER(PART), .ARCH_CODE_RST(ARCH)) i_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .irq_pending, .level_irq, .win);

    irqps_cpu_model i_cpu (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Read one word and compare data and response
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        i_cpu.rd(a, d, r);
        `CHK(d, e)
        `CHK(r, er)
    endtask

    // Write one word and compare the response
    task automatic chk_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        i_cpu.wr(a, d, r);
        `CHK(r, er)
    endtask

    task automatic t_reset_values;
        chk_rd(SCS, {IMPL, 4'h0, ARCH, PART, 4'h0}, OK);
        chk_rd(SCS + irqps_pkg::OFF_ICSR, 32'h0, OK);
        chk_rd(SCS + irqps_pkg::OFF_AIRCR, 32'hfa05_0000, OK);
        chk_rd(SCS + irqps_pkg::OFF_SCR, 32'h0, OK);
        chk_rd(SCS + irqps_pkg::OFF_SHPR2, 32'h0, OK);
        chk_rd(SCS + irqps_pkg::OFF_SHPR3, 32'h0, OK);
        chk_rd(irqps_pkg::OFF_IRQ24_27, 32'h0, OK);
        chk_rd(irqps_pkg::OFF_IRQ28_31, 32'h0, OK);
    endtask

    task automatic t_write_back;
        logic [11:0] offs [5];
        offs = '{irqps_pkg::OFF_ICSR, irqps_pkg::OFF_AIRCR, irqps_pkg::OFF_SCR,
                 irqps_pkg::OFF_SHPR2, irqps_pkg::OFF_SHPR3};
        for (int i = 0; i < 5; i++) begin
            chk_wr(SCS + offs[i], 32'ha5c3_0f90 ^ 32'(i), OK);
            chk_rd(SCS + offs[i], 32'ha5c3_0f90 ^ 32'(i), OK);
        end
        chk_wr(SCS, 32'hffff_ffff, OK);
        chk_rd(SCS, {IMPL, 4'h0, 4'hf, PART, 4'hf}, OK);
        chk_wr(SCS + 12'h008, 32'h1234_5678, irqps_pkg::RESP_DECERR);
        chk_rd(SCS + 12'h008, 32'h0, irqps_pkg::RESP_DECERR);
        chk_wr(irqps_pkg::OFF_IRQ28_31 + 12'h2, 32'hffff_ffff, irqps_pkg::RESP_DECERR);
        chk_rd(irqps_pkg::OFF_IRQ28_31, 32'h0, OK);
    endtask

    task automatic t_levels;
        chk_wr(irqps_pkg::OFF_IRQ24_27, 32'hfcbf_7e3f, OK);
        chk_rd(irqps_pkg::OFF_IRQ24_27, 32'hc080_4000, OK);
        chk_wr(irqps_pkg::OFF_IRQ28_31, 32'h7ffc_3f7f, OK);
        chk_rd(irqps_pkg::OFF_IRQ28_31, 32'h40c0_0040, OK);
        `CHK(level_irq, 16'h71e4)
    endtask

    // Levels now 24:0 25:1 26:2 27:3 28:1 29:0 30:3 31:1
    task automatic t_arbitration;
        logic [7:0] pend [7];
        logic [7:0] exp_win [7];
        pend    = '{8'h00, 8'h09, 8'h8a, 8'h90, 8'hc4, 8'h24, 8'h40};
        exp_win = '{8'h00, 8'he0, 8'he5, 8'hf1, 8'hfd, 8'hf4, 8'hfb};
        for (int i = 0; i < 7; i++) begin
            @(posedge aclk);
            irq_pending <= pend[i];
            repeat (2) @(posedge aclk);
            #1;
            `CHK(win, exp_win[i])
        end
    endtask

    task automatic t_second_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk_rd(irqps_pkg::OFF_IRQ28_31, 32'h0, OK);
        chk_rd(SCS + irqps_pkg::OFF_AIRCR, 32'hfa05_0000, OK);
        `CHK(level_irq, 16'h0)
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        end_of_test;
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_values;
        t_write_back;
        t_levels;
        t_arbitration;
        t_second_reset;
        if (i_cpu.hung) miscompares++;
        end_of_test;
    end
endmodule

`default_nettype wire
